// >>> verilog/cesc_pkg.sv
// Purpose: Constants and types for the comparator event and sleep control
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Register offsets other than the enable set index are chosen here
package cesc_pkg;

  // Printed offset is not a multiple of four, so it is an index
  localparam logic [7:0] IDX_INTEN_SET = 8'h05;
  localparam logic [7:0] IDX_INTEN_CLR = 8'h04;
  localparam logic [7:0] IDX_EVENT_CONTROL_REG    = 8'h02;
  localparam logic [7:0] IDX_COMPCTRL0 = 8'h08;
  localparam logic [7:0] IDX_COMPCTRL1 = 8'h09;
  localparam logic [7:0] IDX_STATUS    = 8'h06;

  // Interrupt enable fields
  localparam int BIT_IE_COMPARATOR_ZERO = 0;
  localparam int BIT_IE_COMPARATOR_ONE = 1;
  localparam int BIT_IE_WIN   = 4;
  localparam logic [7:0] INTEN_MASK  = 8'h13;
  localparam logic [7:0] INTEN_RESET = 8'h00;

  // Event control fields
  localparam int BIT_EO_COMPARATOR_ZERO = 0;
  localparam int BIT_EO_COMPARATOR_ONE = 1;
  localparam int BIT_EO_WIN   = 4;
  localparam int BIT_EI_COMPARATOR_ZERO = 8;
  localparam int BIT_EI_COMPARATOR_ONE = 9;
  localparam logic [15:0] EVENT_CONTROL_REG_MASK  = 16'h0313;
  localparam logic [15:0] EVENT_CONTROL_REG_RESET = 16'h0000;

  // Comparator control fields
  localparam int BIT_CC_ENABLE  = 0;
  localparam int BIT_CC_SINGLE  = 1;
  localparam int BIT_CC_RUNSTBY = 2;
  localparam int BIT_CC_WINDOW  = 3;
  localparam logic [7:0] COMPCTRL_MASK  = 8'h0f;
  localparam logic [7:0] COMPCTRL_RESET = 8'h00;

  // Start-up delay of an analog comparator
  localparam int STARTUP_NS     = 200;
  localparam int CLK_PERIOD_NS  = 8;
  localparam int STARTUP_CYC    = (STARTUP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [7:0] STARTUP_LAST = 8'(STARTUP_CYC - 1);

  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } cesc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cesc_apb_rsp_s;

  typedef struct packed {
    logic win_out;
    logic comparator_one_out;
    logic comparator_zero_out;
  } cesc_evout_s;

  typedef enum logic [3:0] {
    CH_OFF   = 4'b0001,
    CH_START = 4'b0010,
    CH_RUN   = 4'b0100,
    CH_IDLE  = 4'b1000
  } cesc_ch_e;

endpackage

// >>> verilog/cesc_top.sv
// Purpose: Event, standby and interrupt enable control of a comparator pair
// Assumes: Analog results and the window status arrive asynchronously
// Notes:   One clock pclk; clock enable freezes all state while low
//          Window pairing follows the window bit of the first channel
//          Status edges are not captured while the clock is frozen
`timescale 1ns/1ps

module cesc_top (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   clk_en,
  input  wire cesc_pkg::cesc_apb_req_s apb_req,
  output cesc_pkg::cesc_apb_rsp_s     apb_rsp,
  input  wire logic [3:0]             start_event_zero,
  input  wire logic [3:0]             start_event_one,
  input  wire logic                   standby,
  input  wire logic [1:0]             comp_result,
  input  wire logic                   window_inside,
  output cesc_pkg::cesc_evout_s       event_out,
  output logic [1:0]                  comp_power,
  output logic [1:0]                  comp_sample,
  output logic                        clock_request,
  output logic                        wake_request
);

  logic [7:0]  inten;
  logic [15:0] event_control_reg;
  logic [7:0]  comparator_control_reg [2];
  logic [2:0]  sync_a;
  logic [2:0]  sync_b;
  logic [2:0]  sync_prev;
  logic [1:0]  start_hit;
  logic [1:0]  start_go;
  logic [2:0]  edge_seen;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  idx;
  logic [31:0] rd_data;
  logic        rd_err;
  logic        setup_phase;
  logic        wr_inten_set;
  logic        wr_inten_clr;
  logic        wr_event_control_reg;
  logic [1:0]  wr_compctrl;
  logic        pair_window;
  logic [2:0]  sync_edge;

  // Register index from a byte address
  function automatic logic [7:0] word_idx(input logic [7:0] a);
    return {2'b00, a[7:2]};
  endfunction

  // Channel runs in standby only with enable and run bit
  function automatic logic keep_on(input logic [7:0] cc, input logic sb);
    return cc[cesc_pkg::BIT_CC_ENABLE] &
           (!sb | cc[cesc_pkg::BIT_CC_RUNSTBY]);
  endfunction

  // Address map decode for the error answer
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      cesc_pkg::IDX_INTEN_SET,
      cesc_pkg::IDX_INTEN_CLR,
      cesc_pkg::IDX_EVENT_CONTROL_REG,
      cesc_pkg::IDX_COMPCTRL0,
      cesc_pkg::IDX_COMPCTRL1,
      cesc_pkg::IDX_STATUS:    return 1'b1;
      default:                 return 1'b0;
    endcase
  endfunction

  assign idx   = word_idx(apb_req.paddr);
  assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & clk_en;
  assign rd_en = apb_req.psel & !apb_req.pwrite;
  assign setup_phase = apb_req.psel & !apb_req.penable;
  assign pair_window = comparator_control_reg[0][cesc_pkg::BIT_CC_WINDOW];

  // Only the second stage is read, never the metastable first one
  assign sync_edge = sync_b ^ sync_prev;

  // One write strobe for each writable address; status has none
  assign wr_inten_set   = wr_en && idx == cesc_pkg::IDX_INTEN_SET;
  assign wr_inten_clr   = wr_en && idx == cesc_pkg::IDX_INTEN_CLR;
  assign wr_event_control_reg      = wr_en && idx == cesc_pkg::IDX_EVENT_CONTROL_REG;
  assign wr_compctrl[0] = wr_en && idx == cesc_pkg::IDX_COMPCTRL0;
  assign wr_compctrl[1] = wr_en && idx == cesc_pkg::IDX_COMPCTRL1;

  // No wait states: every access phase completes at once
  assign apb_rsp = {rd_data, 1'b1, rd_err};

  // Interrupt enable state, shared by set and clear views
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inten <= cesc_pkg::INTEN_RESET;
    end else if (wr_inten_set) begin
      inten <= inten | (apb_req.pwdata[7:0] & cesc_pkg::INTEN_MASK);
    end else if (wr_inten_clr) begin
      inten <= inten & ~(apb_req.pwdata[7:0] & cesc_pkg::INTEN_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_control_reg <= cesc_pkg::EVENT_CONTROL_REG_RESET;
    end else if (wr_event_control_reg) begin
      event_control_reg <= apb_req.pwdata[15:0] & cesc_pkg::EVENT_CONTROL_REG_MASK;
    end
  end

  // Configuration is only held, never cleared by standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comparator_control_reg[0] <= cesc_pkg::COMPCTRL_RESET;
      comparator_control_reg[1] <= cesc_pkg::COMPCTRL_RESET;
    end else if (wr_compctrl[0]) begin
      comparator_control_reg[0] <= apb_req.pwdata[7:0] &
                                   cesc_pkg::COMPCTRL_MASK;
    end else if (wr_compctrl[1]) begin
      comparator_control_reg[1] <= apb_req.pwdata[7:0] &
                                   cesc_pkg::COMPCTRL_MASK;
    end
  end

  // Read data is taken in the setup phase and stands until the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= 32'h0000_0000;
    end else if (clk_en && rd_en && setup_phase) begin
      case (idx)
        cesc_pkg::IDX_INTEN_SET,
        cesc_pkg::IDX_INTEN_CLR: rd_data <= {24'h0, inten};
        cesc_pkg::IDX_EVENT_CONTROL_REG:    rd_data <= {16'h0, event_control_reg};
        cesc_pkg::IDX_COMPCTRL0: rd_data <= {24'h0, comparator_control_reg[0]};
        cesc_pkg::IDX_COMPCTRL1: rd_data <= {24'h0, comparator_control_reg[1]};
        cesc_pkg::IDX_STATUS:    rd_data <= {29'h0, sync_b};
        default: begin
          rd_data <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Unmapped addresses answer with an error in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_err <= 1'b0;
    end else if (clk_en) begin
      rd_err <= setup_phase & !is_mapped(idx);
    end
  end

  // Two-stage synchroniser for results and window status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a    <= 3'h0;
      sync_b    <= 3'h0;
      sync_prev <= 3'h0;
    end else if (clk_en) begin
      sync_a    <= {window_inside, comp_result};
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  // Any of the routed sources may start a comparison
  assign start_hit[0] = |start_event_zero &
                        event_control_reg[cesc_pkg::BIT_EI_COMPARATOR_ZERO];
  assign start_hit[1] = |start_event_one &
                        event_control_reg[cesc_pkg::BIT_EI_COMPARATOR_ONE];

  // Window pairing joins both starts; otherwise each is alone
  always_comb begin
    if (pair_window) begin
      start_go = {2{|start_hit}};
    end else begin
      start_go = start_hit;
    end
  end

  // Per-comparator power and sample sequencing
  for (genvar g = 0; g < 2; g++) begin : g_ch
    cesc_pkg::cesc_ch_e state;
    logic [7:0]         cnt;
    logic               single;
    logic               on;

    assign single = comparator_control_reg[g][cesc_pkg::BIT_CC_SINGLE];
    assign on     = keep_on(comparator_control_reg[g], standby);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state <= cesc_pkg::CH_OFF;
        cnt   <= 8'h00;
      end else if (clk_en) begin
        case (state)
          cesc_pkg::CH_OFF: begin
            cnt <= 8'h00;
            if (on && (!single || start_go[g])) begin
              state <= cesc_pkg::CH_START;
            end
          end
          cesc_pkg::CH_START: begin
            if (!on) begin
              state <= cesc_pkg::CH_OFF;
            end else if (cnt == cesc_pkg::STARTUP_LAST) begin
              state <= single ? cesc_pkg::CH_RUN : cesc_pkg::CH_IDLE;
            end else begin
              cnt <= cnt + 8'h01;
            end
          end
          cesc_pkg::CH_RUN: begin
            state <= single ? cesc_pkg::CH_OFF : cesc_pkg::CH_IDLE;
          end
          cesc_pkg::CH_IDLE: begin
            // Continuous mode keeps power on through standby only with the run bit set
            if (!on) begin
              state <= cesc_pkg::CH_OFF;
            end else if (single) begin
              state <= cesc_pkg::CH_OFF;
            end
          end
          default: state <= cesc_pkg::CH_OFF;
        endcase
      end
    end

    assign comp_power[g]  = state != cesc_pkg::CH_OFF;
    assign comp_sample[g] = state == cesc_pkg::CH_RUN ||
                            state == cesc_pkg::CH_IDLE;
  end

  // Edge catch of each status bit, kept for one enabled cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_seen <= 3'h0;
    end else if (clk_en) begin
      edge_seen <= sync_edge & {comp_sample[0], comp_sample};
    end
  end

  // Output events copy synchronised status when enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_out <= '0;
    end else if (clk_en) begin
      event_out.comparator_zero_out <= sync_b[0] & comp_sample[0] &
                   event_control_reg[cesc_pkg::BIT_EO_COMPARATOR_ZERO];
      event_out.comparator_one_out <= sync_b[1] & comp_sample[1] &
                   event_control_reg[cesc_pkg::BIT_EO_COMPARATOR_ONE];
      event_out.win_out   <= sync_b[2] & &comp_sample &
                   event_control_reg[cesc_pkg::BIT_EO_WIN];
    end
  end

  // Asynchronous status change in standby asks for the clock back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_request <= 1'b0;
    end else if (clk_en) begin
      clock_request <= standby & |sync_edge;
    end
  end

  // Wake only for sources whose interrupt is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request <= 1'b0;
    end else if (clk_en) begin
      wake_request <= standby &
        ((edge_seen[0] & inten[cesc_pkg::BIT_IE_COMPARATOR_ZERO]) |
         (edge_seen[1] & inten[cesc_pkg::BIT_IE_COMPARATOR_ONE]) |
         (edge_seen[2] & inten[cesc_pkg::BIT_IE_WIN]));
    end
  end

endmodule // cesc_top

// >>> dv/cesc_checker.sv
// Purpose: Port assertions for the comparator event and sleep control
// Assumes: One pclk domain, asynchronous active-low reset
// Notes:   Figures follow the hand-over latencies
`timescale 1ns/1ps

module cesc_checker (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire cesc_pkg::cesc_apb_req_s apb_req,
  input wire cesc_pkg::cesc_apb_rsp_s apb_rsp,
  input wire logic                    standby,
  input wire logic [1:0]              comp_result,
  input wire logic                    window_inside,
  input wire cesc_pkg::cesc_evout_s   event_out,
  input wire logic [1:0]              comp_power,
  input wire logic [1:0]              comp_sample,
  input wire logic                    clock_request,
  input wire logic                    wake_request
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  assign acc = apb_req.psel && apb_req.penable;
  assign mapped = apb_req.paddr[7:2] inside {6'h2, 6'h4, 6'h5, 6'h6,
                                             6'h8, 6'h9};
  sequence s_up0; $rose(comp_power[0]); endsequence
  sequence s_up1; $rose(comp_power[1]); endsequence
  a_comparator_zero_follow: assert property ($rose(event_out.comparator_zero_out) |->
    $past(comp_result[0], 2) && $past(comp_result[0], 3))
    else $error("comparator_zero event without result");
  a_comparator_one_follow: assert property ($rose(event_out.comparator_one_out) |->
    $past(comp_result[1], 2) && $past(comp_result[1], 3))
    else $error("comparator_one event without result");
  a_win_follow: assert property ($rose(event_out.win_out) |->
    $past(window_inside, 2) && $past(window_inside, 3))
    else $error("window event without status");
  a_start_wait0: assert property (s_up0 |-> !comp_sample[0] [*8])
    else $error("comparator_zero sampled too early");
  a_start_wait1: assert property (s_up1 |-> !comp_sample[1] [*8])
    else $error("comparator_one sampled too early");
  a_sample_power: assert property (
    (comp_sample & ~$past(comp_power, 8)) == 2'b00)
    else $error("sample while unpowered");
  a_wake_sleep: assert property ($rose(wake_request) |-> $past(standby))
    else $error("wake outside standby");
  a_clk_sleep: assert property ($rose(clock_request) |-> $past(standby))
    else $error("clock request outside standby");
  a_err_unmap: assert property (acc && !mapped |-> apb_rsp.pslverr)
    else $error("no error on unmapped");
  a_err_mapped: assert property (acc && mapped |-> !apb_rsp.pslverr)
    else $error("error on mapped");
endmodule // cesc_checker

bind cesc_top cesc_checker u_cesc_checker (.*);

// >>> dv/cesc_fabric.sv
// Purpose: Event routing fabric and wake logic beside the comparator block
// Assumes: Start events are one-cycle pulses in the pclk domain
// Notes:   Source line chosen at random per pulse, so at most three routes are exercised
`timescale 1ns/1ps

module cesc_fabric (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] fire,
  input  wire logic [1:0] src,
  input  wire logic       clock_request,
  output logic [3:0]      start_event_zero,
  output logic [3:0]      start_event_one,
  output logic            saw_clock
);
  // Start line registered each cycle from the request, so a held request keeps retriggering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_event_zero <= 4'h0;
      start_event_one  <= 4'h0;
    end else begin
      start_event_zero <= fire[0] ? 4'h1 << src : 4'h0;
      start_event_one  <= fire[1] ? 4'h1 << src : 4'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) saw_clock <= 1'b0;
    else saw_clock <= saw_clock | clock_request;
  end
endmodule // cesc_fabric

// >>> dv/tb_cesc_top.sv
// Purpose: Self-checking bench for the comparator event and sleep control
// Assumes: APB slave answers with pready, read data in the access phase
// Notes:   Reads are checked by a monitor against queued expectations
`timescale 1ns/1ps

module tb_cesc_top;
  logic                    pclk;
  logic                    presetn;
  cesc_pkg::cesc_apb_req_s req;
  cesc_pkg::cesc_apb_rsp_s rsp;
  logic [3:0]              sev0;
  logic [3:0]              sev1;
  logic                    standby;
  logic [1:0]              comp_result;
  logic                    window_inside;
  cesc_pkg::cesc_evout_s   ev;
  logic [1:0]              pwr;
  logic [1:0]              smp;
  logic                    clk_req;
  logic                    wake;
  logic [1:0]              fire;
  logic [1:0]              src;
  logic                    saw_clock;
  logic [1:0]              r;
  logic [31:0]             d;
  logic [32:0]             expq[$];
  integer                  seed = 32'h2ce08d67;
  int                      n_fail;
  int                      n_compared;
  int                      cyc;
  int                      n;

  cesc_top u_cesc_top (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .apb_req(req), .apb_rsp(rsp), .start_event_zero(sev0),
    .start_event_one(sev1), .standby(standby), .comp_result(comp_result),
    .window_inside(window_inside), .event_out(ev), .comp_power(pwr),
    .comp_sample(smp), .clock_request(clk_req), .wake_request(wake));
  cesc_fabric u_cesc_fabric (.pclk(pclk), .presetn(presetn), .fire(fire),
    .src(src), .clock_request(clk_req), .start_event_zero(sev0),
    .start_event_one(sev1), .saw_clock(saw_clock));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge pclk);
    req <= '{a, w, wd, 1'b1, 1'b0};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb(a, 1'b1, wd);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(a, 1'b0, 32'h0);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // Wake stands one cycle only, so it is watched over a window
  task automatic watch_wake(output int k);
    k = 0;
    while (wake !== 1'b1 && k < 12) begin
      @(posedge pclk);
      k++;
    end
  endtask

  task automatic kick(input logic [1:0] f);
    @(posedge pclk);
    src <= 2'($random(seed));
    fire <= f;
    @(posedge pclk);
    fire <= 2'b00;
  endtask

  // Old values are seen here, so the compare never races the bus driver
  always @(posedge pclk) begin
    if (req.psel && req.penable && rsp.pready && !req.pwrite)
      cmp({rsp.pslverr, rsp.prdata}, expq.pop_front());
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      stop_test();
    end
  end

  initial begin
    presetn = 1'b0;
    req = '0;
    fire = 2'b00;
    src = 2'b00;
    standby = 1'b0;
    comp_result = 2'b00;
    window_inside = 1'b0;
    tick(3);
    presetn <= 1'b1;
    rd(8'h14, 33'h0);
    wr(8'h14, 32'h13);
    wr(8'h14, 32'h0);
    rd(8'h14, 33'h13);
    rd(8'h10, 33'h13);
    wr(8'h10, 32'h1);
    rd(8'h14, 33'h12);
    rd(8'h3c, {1'b1, 32'h0});
    d = $random(seed);
    wr(8'h08, d);
    rd(8'h08, {1'b0, d & 32'h313});
    $display("test registers done");
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h1);
    tick(30);
    wr(8'h08, 32'h13);
    r = 2'($random(seed));
    comp_result <= r;
    window_inside <= 1'b1;
    tick(5);
    cmp(33'(ev), {30'h0, 1'b1, r});
    wr(8'h08, 32'h12);
    tick(4);
    cmp(33'(ev), {30'h0, 1'b1, r[1], 1'b0});
    $display("test events done");
    wr(8'h20, 32'h3);
    wr(8'h24, 32'h3);
    wr(8'h08, 32'h100);
    tick(2);
    cmp(33'(pwr), 33'h0);
    kick(2'b10);
    tick(3);
    cmp(33'(pwr), 33'h0);
    kick(2'b01);
    tick(3);
    cmp(33'(pwr), 33'h1);
    n = 0;
    while (smp[0] !== 1'b1 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    cmp(33'(n >= 20 && n < 60), 33'h1);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h0);
    wr(8'h20, 32'hb);
    wr(8'h24, 32'h3);
    wr(8'h08, 32'h200);
    kick(2'b10);
    tick(3);
    cmp(33'(pwr), 33'h3);
    $display("test starts done");
    wr(8'h20, 32'h1);
    wr(8'h24, 32'h5);
    tick(3);
    cmp(33'(pwr), 33'h3);
    standby <= 1'b1;
    tick(3);
    cmp(33'(pwr), 33'h2);
    rd(8'h20, 33'h1);
    standby <= 1'b0;
    tick(3);
    cmp(33'(smp[0]), 33'h0);
    standby <= 1'b1;
    tick(30);
    comp_result[1] <= ~comp_result[1];
    watch_wake(n);
    cmp(33'(n < 12), 33'h1);
    cmp(33'(saw_clock), 33'h1);
    standby <= 1'b0;
    wr(8'h10, 32'h13);
    standby <= 1'b1;
    tick(3);
    comp_result[1] <= ~comp_result[1];
    watch_wake(n);
    cmp(33'(n), 33'hc);
    $display("test standby done");
    stop_test();
  end
endmodule // tb_cesc_top
